//--- pkg/eicfg_pkg.sv
// package for the external interrupt pin configuration block
package eicfg_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 16;
    localparam logic [11:0] CFG_LO_OFFS = 12'ha20;
    localparam logic [11:0] CFG_HI_OFFS = 12'ha24;
    localparam logic [11:0] CLR_OFFS = 12'ha30;
    localparam logic [15:0] CFG_LO_RST = 16'h0000;
    localparam logic [15:0] CFG_HI_RST = 16'h0000;
    localparam logic [15:0] CLR_RST = 16'hc000;
    // field positions inside a configuration register
    localparam int unsigned SRC0_EN_BIT = 3;
    localparam int unsigned SRC0_MODE_LSB = 0;
    localparam int unsigned SRC1_EN_BIT = 7;
    localparam int unsigned SRC1_MODE_LSB = 4;
    localparam int unsigned MODE_W = 3;
    localparam int unsigned NSRC = 2;

    typedef enum logic [2:0] {
        EICFG_RISE = 3'h0,
        EICFG_FALL = 3'h1,
        EICFG_BOTH = 3'h2,
        EICFG_HIGH = 3'h3,
        EICFG_LOW = 3'h4,
        EICFG_FALL_A = 3'h5,
        EICFG_BOTH_A = 3'h6,
        EICFG_HIGH_A = 3'h7
    } eicfg_mode_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } eicfg_bus_s;

    typedef struct packed {
        logic [DATA_W-1:0] cfg_lo;
        logic [DATA_W-1:0] cfg_hi;
        logic [DATA_W-1:0] clr;
        logic [NSRC-1:0] sync1;
        logic [NSRC-1:0] sync2;
        logic [NSRC-1:0] prev;
        logic [NSRC-1:0] irq;
        logic [NSRC-1:0] wake;
        logic [DATA_W-1:0] rdata;
    } eicfg_state_s;
endpackage

//--- rtl/eicfg_top.sv
// external interrupt source 0/1 configuration, sensing and wake requests
// Overview of operation
// - bit 7 enables source 1; one enables, resets to zero
// - enabled source 1 lets an event on pin 1 wake from hibernate
// - bits 6:4 pick source 1 sense: rise, fall, both, high, low
// - codes 101, 110, 111 alias falling, either edge and high level
// - bit 3 enables source 0; one enables, resets to zero
// - enabled source 0 lets an event on pin 0 wake from hibernate
// - bits 2:0 pick source 0 sense with the same code mapping
// - second configuration register at 0xa24, resets to zero
// - first configuration register at 0xa20, resets to zero
// - clear register at 0xa30, resets to 0xc000
`timescale 1ns/10ps
module eicfg_top (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [11:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic input_pin_0_i,
    input wire logic input_pin_1_i,
    input wire logic hibernate_i,
    output logic [15:0] rdata_o,
    output logic [1:0] irq_o,
    output logic [1:0] wake_o
);
    eicfg_pkg::eicfg_bus_s bus;
    eicfg_pkg::eicfg_state_s st_reg;
    eicfg_pkg::eicfg_state_s st_next;
    logic [1:0] pins;
    logic [1:0] en;
    logic [1:0] hit;
    logic [2:0] mode0;
    logic [2:0] mode1;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign pins = {input_pin_1_i, input_pin_0_i};

    assign en[1] = st_reg.cfg_lo[eicfg_pkg::SRC1_EN_BIT];
    assign en[0] = st_reg.cfg_lo[eicfg_pkg::SRC0_EN_BIT];
    assign mode1 = st_reg.cfg_lo[eicfg_pkg::SRC1_MODE_LSB +: eicfg_pkg::MODE_W];
    assign mode0 = st_reg.cfg_lo[eicfg_pkg::SRC0_MODE_LSB +: eicfg_pkg::MODE_W];

    function automatic logic sense(input logic [2:0] m, input logic cur, input logic old);
        // aliased codes decode like their base codes
        case (eicfg_pkg::eicfg_mode_e'(m))
            eicfg_pkg::EICFG_RISE: sense = cur & ~old;
            eicfg_pkg::EICFG_FALL, eicfg_pkg::EICFG_FALL_A: sense = ~cur & old;
            eicfg_pkg::EICFG_BOTH, eicfg_pkg::EICFG_BOTH_A: sense = cur ^ old;
            eicfg_pkg::EICFG_HIGH, eicfg_pkg::EICFG_HIGH_A: sense = cur;
            eicfg_pkg::EICFG_LOW: sense = ~cur;
            default: sense = 1'b0;
        endcase
    endfunction

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_src
            assign hit[g] = sense((g == 0) ? mode0 : mode1, st_reg.sync2[g], st_reg.prev[g]);
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        st_next.sync1 = pins;
        st_next.sync2 = st_reg.sync1;
        st_next.prev = st_reg.sync2;
        st_next.irq = hit & en;
        // wake only in hibernate with source enabled
        st_next.wake = hit & en & {2{hibernate_i}};
        if (bus.wr) begin
            case (bus.addr)
                eicfg_pkg::CFG_LO_OFFS: st_next.cfg_lo = bus.wdata;
                eicfg_pkg::CFG_HI_OFFS: st_next.cfg_hi = bus.wdata;
                eicfg_pkg::CLR_OFFS: st_next.clr = bus.wdata;
                default: st_next.cfg_lo = st_reg.cfg_lo;
            endcase
        end
        st_next.rdata = '0;
        if (bus.rd) begin
            case (bus.addr)
                eicfg_pkg::CFG_LO_OFFS: st_next.rdata = st_reg.cfg_lo;
                eicfg_pkg::CFG_HI_OFFS: st_next.rdata = st_reg.cfg_hi;
                eicfg_pkg::CLR_OFFS: st_next.rdata = st_reg.clr;
                default: st_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            st_reg <= '{cfg_lo: eicfg_pkg::CFG_LO_RST, cfg_hi: eicfg_pkg::CFG_HI_RST,
                        clr: eicfg_pkg::CLR_RST, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_o = st_reg.rdata;
    assign irq_o = st_reg.irq;
    assign wake_o = st_reg.wake;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    property p_en_gate;
        !en[0] |=> !irq_o[0];
    endproperty
    a_en_gate: assert property (p_en_gate) else $error("src0 irq while disabled");

    property p_en1_gate;
        !en[1] |=> !irq_o[1];
    endproperty
    a_en1_gate: assert property (p_en1_gate) else $error("src1 irq while disabled");

    property p_rise1;
        en[1] && mode1 == 3'h0 && st_reg.sync2[1] && !st_reg.prev[1] |=> irq_o[1];
    endproperty
    a_rise1: assert property (p_rise1) else $error("src1 rising edge missed");

    property p_low0;
        en[0] && mode0 == 3'h4 && !st_reg.sync2[0] |=> irq_o[0];
    endproperty
    a_low0: assert property (p_low0) else $error("src0 low level missed");

    property p_alias;
        en[0] && mode0 == 3'h7 && !st_reg.sync2[0] |=> !irq_o[0];
    endproperty
    a_alias: assert property (p_alias) else $error("alias high level wrong");

    property p_pin_delay;
        en[0] && mode0 == 3'h3 && $past(pins[0], 2) && pins[0] && $past(pins[0]) |=> irq_o[0];
    endproperty
    a_pin_delay: assert property (p_pin_delay) else $error("sync latency wrong");

    property p_wake1;
        wake_o[1] |-> $past(hibernate_i) && $past(en[1]);
    endproperty
    a_wake1: assert property (p_wake1) else $error("src1 wake without enable");

    property p_wake0;
        wake_o[0] |-> $past(hibernate_i) && irq_o[0];
    endproperty
    a_wake0: assert property (p_wake0) else $error("src0 wake without event");

    property p_rd_hi;
        rd_i && addr_i == eicfg_pkg::CFG_HI_OFFS |=> rdata_o == $past(st_reg.cfg_hi);
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("hi config read wrong");

    property p_rd_clr;
        rd_i && addr_i == eicfg_pkg::CLR_OFFS |=> rdata_o == $past(st_reg.clr);
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("clear reg read wrong");

    property p_wr_lo;
        wr_i && addr_i == eicfg_pkg::CFG_LO_OFFS |=> st_reg.cfg_lo == $past(wdata_i);
    endproperty
    a_wr_lo: assert property (p_wr_lo) else $error("lo config write lost");

    // short names for the sensed pin history, so the checks below stay readable
    logic [1:0] cur;
    logic [1:0] old;
    assign cur = st_reg.sync2;
    assign old = st_reg.prev;

    property p_rise0;
        en[0] && mode0 == eicfg_pkg::EICFG_RISE && cur[0] && !old[0] |=> irq_o[0];
    endproperty
    a_rise0: assert property (p_rise0) else $error("src0 rise missed");

    property p_rise0_quiet;
        en[0] && mode0 == eicfg_pkg::EICFG_RISE && !(cur[0] && !old[0]) |=> !irq_o[0];
    endproperty
    a_rise0_quiet: assert property (p_rise0_quiet) else $error("src0 spurious rise");

    property p_fall0;
        en[0] && mode0 == eicfg_pkg::EICFG_FALL && !cur[0] && old[0] |=> irq_o[0];
    endproperty
    a_fall0: assert property (p_fall0) else $error("src0 fall missed");

    property p_fall0a;
        en[0] && mode0 == eicfg_pkg::EICFG_FALL_A && !cur[0] && old[0] |=> irq_o[0];
    endproperty
    a_fall0a: assert property (p_fall0a) else $error("src0 alias fall missed");

    property p_both0;
        en[0] && mode0 == eicfg_pkg::EICFG_BOTH && cur[0] != old[0] |=> irq_o[0];
    endproperty
    a_both0: assert property (p_both0) else $error("src0 either edge missed");

    property p_both0a;
        en[0] && mode0 == eicfg_pkg::EICFG_BOTH_A && cur[0] != old[0] |=> irq_o[0];
    endproperty
    a_both0a: assert property (p_both0a) else $error("src0 alias edge missed");

    property p_high0;
        en[0] && mode0 == eicfg_pkg::EICFG_HIGH && cur[0] |=> irq_o[0];
    endproperty
    a_high0: assert property (p_high0) else $error("src0 high level missed");

    property p_high0a;
        en[0] && mode0 == eicfg_pkg::EICFG_HIGH_A && cur[0] |=> irq_o[0];
    endproperty
    a_high0a: assert property (p_high0a) else $error("src0 alias high missed");

    property p_low0_quiet;
        en[0] && mode0 == eicfg_pkg::EICFG_LOW && cur[0] |=> !irq_o[0];
    endproperty
    a_low0_quiet: assert property (p_low0_quiet) else $error("src0 low while high");

    property p_fall1;
        en[1] && mode1 == eicfg_pkg::EICFG_FALL && !cur[1] && old[1] |=> irq_o[1];
    endproperty
    a_fall1: assert property (p_fall1) else $error("src1 fall missed");

    property p_fall1a;
        en[1] && mode1 == eicfg_pkg::EICFG_FALL_A && !cur[1] && old[1] |=> irq_o[1];
    endproperty
    a_fall1a: assert property (p_fall1a) else $error("src1 alias fall missed");

    property p_fall1_quiet;
        en[1] && mode1 == eicfg_pkg::EICFG_FALL && !(!cur[1] && old[1]) |=> !irq_o[1];
    endproperty
    a_fall1_quiet: assert property (p_fall1_quiet) else $error("src1 spurious fall");

    property p_both1;
        en[1] && mode1 == eicfg_pkg::EICFG_BOTH && cur[1] != old[1] |=> irq_o[1];
    endproperty
    a_both1: assert property (p_both1) else $error("src1 either edge missed");

    property p_both1a;
        en[1] && mode1 == eicfg_pkg::EICFG_BOTH_A && cur[1] != old[1] |=> irq_o[1];
    endproperty
    a_both1a: assert property (p_both1a) else $error("src1 alias edge missed");

    property p_high1;
        en[1] && mode1 == eicfg_pkg::EICFG_HIGH && cur[1] |=> irq_o[1];
    endproperty
    a_high1: assert property (p_high1) else $error("src1 high level missed");

    property p_high1a;
        en[1] && mode1 == eicfg_pkg::EICFG_HIGH_A && cur[1] |=> irq_o[1];
    endproperty
    a_high1a: assert property (p_high1a) else $error("src1 alias high missed");

    property p_low1;
        en[1] && mode1 == eicfg_pkg::EICFG_LOW && !cur[1] |=> irq_o[1];
    endproperty
    a_low1: assert property (p_low1) else $error("src1 low level missed");

    property p_low1_quiet;
        en[1] && mode1 == eicfg_pkg::EICFG_LOW && cur[1] |=> !irq_o[1];
    endproperty
    a_low1_quiet: assert property (p_low1_quiet) else $error("src1 low while high");

    property p_rd_lo;
        rd_i && addr_i == eicfg_pkg::CFG_LO_OFFS |=> rdata_o == $past(st_reg.cfg_lo);
    endproperty
    a_rd_lo: assert property (p_rd_lo) else $error("lo config read wrong");

    property p_wr_hi;
        wr_i && addr_i == eicfg_pkg::CFG_HI_OFFS |=> st_reg.cfg_hi == $past(wdata_i);
    endproperty
    a_wr_hi: assert property (p_wr_hi) else $error("hi config write lost");

    property p_wr_clr;
        wr_i && addr_i == eicfg_pkg::CLR_OFFS |=> st_reg.clr == $past(wdata_i);
    endproperty
    a_wr_clr: assert property (p_wr_clr) else $error("clear reg write lost");

    property p_rd_unmapped;
        rd_i && addr_i != eicfg_pkg::CFG_LO_OFFS && addr_i != eicfg_pkg::CFG_HI_OFFS
            && addr_i != eicfg_pkg::CLR_OFFS |=> rdata_o == '0;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_rd_idle;
        !rd_i |=> rdata_o == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");

    property p_wr_unmapped;
        wr_i && addr_i != eicfg_pkg::CFG_LO_OFFS && addr_i != eicfg_pkg::CFG_HI_OFFS
            && addr_i != eicfg_pkg::CLR_OFFS
            |=> $stable(st_reg.cfg_lo) && $stable(st_reg.cfg_hi) && $stable(st_reg.clr);
    endproperty
    a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write landed");

    property p_wake_sleep;
        !hibernate_i |=> wake_o == 2'h0;
    endproperty
    a_wake_sleep: assert property (p_wake_sleep) else $error("wake while awake");

    property p_wake_fire1;
        en[1] && hibernate_i && mode1 == eicfg_pkg::EICFG_RISE && cur[1] && !old[1] |=> wake_o[1];
    endproperty
    a_wake_fire1: assert property (p_wake_fire1) else $error("src1 wake missed");

    property p_wake_fire0;
        en[0] && hibernate_i && mode0 == eicfg_pkg::EICFG_RISE && cur[0] && !old[0] |=> wake_o[0];
    endproperty
    a_wake_fire0: assert property (p_wake_fire0) else $error("src0 wake missed");

    c_irq0: cover property (irq_o[0]);
    c_irq1: cover property (irq_o[1]);
    c_wake: cover property (wake_o != 2'h0);
    c_both: cover property (en[1] && mode1 == 3'h6 && irq_o[1]);
endmodule

//--- tb/eicfg_pin_model.sv
// model of the outside world driving the two external input pins
`timescale 1ns/10ps
module eicfg_pin_model (
    input wire logic clock_i,
    input wire logic [1:0] level_i,
    output logic input_pin_0_o,
    output logic input_pin_1_o
);
    // pins are asynchronous: move them on the falling edge, well away from sampling
    always @(negedge clock_i) begin
        input_pin_0_o <= level_i[0];
        input_pin_1_o <= level_i[1];
    end
endmodule

//--- tb/eicfg_top_tb.sv
// self-checking bench for the external interrupt configuration block
`timescale 1ns/10ps
module eicfg_top_tb;
    logic clock_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, hib = 0, p0, p1;
    logic [11:0] addr_i = 12'h000;
    logic [15:0] wdata_i = 16'h0000, rdata_o;
    logic [1:0] irq_o, wake_o, lvl = 2'h0;
    logic [7:0] ni, nw;
    int num_errors = 0, samples_checked = 0;
    int er[5] = '{1, 0, 1, 5, 2};
    int ef[5] = '{0, 1, 1, 2, 5};
    always #25 clock_i = ~clock_i;
    eicfg_pin_model pins (.clock_i(clock_i), .level_i(lvl), .input_pin_0_o(p0),
        .input_pin_1_o(p1));
    eicfg_top dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .input_pin_0_i(p0), .input_pin_1_i(p1), .hibernate_i(hib),
        .rdata_o(rdata_o), .irq_o(irq_o), .wake_o(wake_o));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clock_i);
        addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [15:0] exp);
        @(posedge clock_i);
        addr_i <= a; rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask
    task cnt(input int s);
        ni = 0; nw = 0;
        repeat (7) begin
            @(posedge clock_i);
            #1 ni = ni + irq_o[s];
            nw = nw + wake_o[s];
        end
    endtask
    task t_regs;
        // reset values, then storage and unmapped space
        rd(12'ha20, 16'h0000);
        rd(12'ha24, 16'h0000);
        rd(12'ha30, 16'hc000);
        wr(12'ha24, 16'ha5c3);
        wr(12'ha2c, 16'hffff);
        wr(12'ha30, 16'h1234);
        rd(12'ha24, 16'ha5c3);
        rd(12'ha2c, 16'h0000);
        rd(12'ha30, 16'h1234);
    endtask
    // reset in mid-run with both sources requesting: outputs and registers must return
    task t_rst;
        wr(12'ha20, 16'h00cc);
        wr(12'ha24, 16'h00ff);
        wr(12'ha30, 16'h0000);
        @(posedge clock_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        #1 chk({12'h000, wake_o, irq_o}, 16'h0000);
        rd(12'ha20, 16'h0000);
        rd(12'ha24, 16'h0000);
        rd(12'ha30, 16'hc000);
    endtask
    // each code of each source: count request cycles across a rising then falling pin
    task t_mode(input int s, input int c, input bit en);
        wr(12'ha20, 16'((en ? 8 + c : c) << (4 * s)));
        hib <= (c == 0);
        repeat (8) @(posedge clock_i);
        lvl[s] <= 1'b1;
        cnt(s);
        chk(ni, en ? er[c > 4 ? c - 4 : c] : 0);
        chk(nw, (en && c == 0) ? 1 : 0);
        @(posedge clock_i);
        lvl[s] <= 1'b0;
        cnt(s);
        chk(ni, en ? ef[c > 4 ? c - 4 : c] : 0);
        chk(nw, 16'h0000);
    endtask
    task print_verdict;
        $display("errors %0d of %0d checks", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock_i);
        nrst_i <= 1'b1;
        t_regs;
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 8; c++) t_mode(s, c, 1'b1);
            t_mode(s, 0, 1'b0);
            t_mode(s, 3, 1'b0);
        end
        t_rst;
        print_verdict;
    end
    initial begin
        #200us;
        num_errors++;
        print_verdict;
    end
endmodule
